// *** hw/t2rc_pkg.sv ***
// Constants, register map and mode type for the reload/capture/baud timer.
// Assumes an 8-bit special function register bus on the core clock.
package t2rc_pkg;

  localparam int unsigned T2RC_BYTE_W = 8;
  localparam int unsigned T2RC_CNT_W  = 16;

  // Special function register addresses
  localparam logic [7:0] T2RC_ADDR_CTRL    = 8'hc8;
  localparam logic [7:0] T2RC_ADDR_HOLD_LO = 8'hca;
  localparam logic [7:0] T2RC_ADDR_HOLD_HI = 8'hcb;
  localparam logic [7:0] T2RC_ADDR_CNT_LO  = 8'hcc;
  localparam logic [7:0] T2RC_ADDR_CNT_HI  = 8'hcd;

  // Control register bit positions
  localparam int unsigned T2RC_BIT_OVF   = 7;
  localparam int unsigned T2RC_BIT_EXF   = 6;
  localparam int unsigned T2RC_BIT_RCLK  = 5;
  localparam int unsigned T2RC_BIT_TRANSMIT_CLOCK_SELECT  = 4;
  localparam int unsigned T2RC_BIT_EXEN  = 3;
  localparam int unsigned T2RC_BIT_RUN   = 2;
  localparam int unsigned T2RC_BIT_CNTS  = 1;
  localparam int unsigned T2RC_BIT_CAPS  = 0;

  // Reset values and 16-bit count constants
  localparam logic [7:0]  T2RC_CTRL_RST  = 8'h00;
  localparam logic [7:0]  T2RC_BYTE_RST  = 8'h00;
  localparam logic [7:0]  T2RC_RDATA_NIL = 8'h00;
  localparam logic [15:0] T2RC_CNT_MAX   = 16'hffff;
  localparam logic [15:0] T2RC_CNT_ZERO  = 16'h0000;
  localparam logic [15:0] T2RC_CNT_ONE   = 16'h0001;

  // Pin samplers: index of each pin in the sampler vector, pin count and idle level
  localparam int unsigned T2RC_PIN_COUNT = 0;
  localparam int unsigned T2RC_PIN_TRIG  = 1;
  localparam int unsigned T2RC_PIN_NUM   = 2;
  localparam logic        T2RC_PIN_IDLE  = 1'b1;

  typedef enum logic [1:0] {
    T2RC_MODE_OFF,
    T2RC_MODE_RELOAD,
    T2RC_MODE_CAPTURE,
    T2RC_MODE_BAUD
  } t2rc_mode_t;

endpackage : t2rc_pkg

// *** hw/t2rc_ctl_if.sv ***
// Carrier of the control bits into the mode decoder and the mode back out.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/100ps
interface t2rc_ctl_if;
  import t2rc_pkg::*;
  logic       run_control;
  logic       capture_select;
  logic       receive_clock_select;
  logic       transmit_clock_select;
  t2rc_mode_t mode;

  modport src (output run_control, output capture_select, output receive_clock_select,
               output transmit_clock_select, input mode);
  modport dec (input run_control, input capture_select, input receive_clock_select,
               input transmit_clock_select, output mode);
endinterface : t2rc_ctl_if

// *** hw/t2rc_mode_dec.sv ***
// Mode decoder: maps the control bits onto the four operating modes.
// Assumes the control bits come straight from the control register.
`timescale 1ns/100ps
module t2rc_mode_dec
  import t2rc_pkg::*;
(
  t2rc_ctl_if.dec ctl  // Control bits in, mode out
);

  always_comb begin
    if (!ctl.run_control) begin
      ctl.mode = T2RC_MODE_OFF;  // RQ4
    end else if (ctl.receive_clock_select || ctl.transmit_clock_select) begin
      ctl.mode = T2RC_MODE_BAUD;  // RQ5
    end else if (ctl.capture_select) begin
      ctl.mode = T2RC_MODE_CAPTURE;  // RQ4
    end else begin
      ctl.mode = T2RC_MODE_RELOAD;  // RQ4
    end
  end

endmodule : t2rc_mode_dec

// *** hw/t2rc_fall_det.sv ***
// Pin sampler: two-stage synchroniser and falling edge detector.
// Assumes the pin idles high; one pulse per 1-to-0 transition.
`timescale 1ns/100ps
module t2rc_fall_det
  import t2rc_pkg::*;
(
  input  wire logic clk_sys_i,  // Core clock
  input  wire logic rst_n_i,    // Synchronised reset, active low
  input  wire logic pin_i,      // Raw pin level
  output logic      fall_o      // One-cycle pulse on falling edge
);

  logic meta_ff, sync_ff, last_ff;
  logic nxt_meta, nxt_sync, nxt_last;

  always_comb begin
    nxt_meta = pin_i;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= T2RC_PIN_IDLE;
      sync_ff <= T2RC_PIN_IDLE;
      last_ff <= T2RC_PIN_IDLE;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  // Only the second stage and its delayed copy are compared
  assign fall_o = last_ff & ~sync_ff;  // RQ17

  AST_FALL_ONCE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    fall_o |=> !fall_o)  // RQ17
    else $error("falling edge pulse lasted more than one cycle");

endmodule : t2rc_fall_det

// *** hw/t2rc_top.sv ***
// Reload/capture/baud timer: 16-bit count, holding bytes, control register.
// Assumes a byte-wide register port on the core clock and pins synchronous-safe via samplers.
//
// How it works
// [RQ1] Two byte pairs: live count and capture/reload holding value.
// [RQ2] Live count high and low bytes sit at CDH and CCH.
// [RQ3] Holding high and low bytes sit at CBH and CAH.
// [RQ4] Run clear means off; otherwise capture select picks capture or autoreload.
// [RQ5] Run set with either clock select gives baud mode, capture select ignored.
// [RQ6] Autoreload: each rollover sets overflow flag and loads count from holding bytes.
// [RQ7] Autoreload with trigger enable: trigger falling edge reloads and sets event flag.
// [RQ8] Capture without trigger enable: plain 16-bit counter, overflow flag, no reload.
// [RQ9] Capture with trigger enable: trigger falling edge copies count into holding bytes.
// [RQ10] Each trigger-driven capture also sets the external-event flag.
// [RQ11] Overflow and external-event flags both request an interrupt.
// [RQ12] Baud mode never sets the overflow flag.
// [RQ13] Baud mode still lets the external-event flag request interrupts.
// [RQ14] Control bits 7..0: ovf, ext, rclk, transmit_clock_select, trig en, run, cnt, cap; reset zero.
// [RQ15] Hardware only sets the two flags; software clears them.
// [RQ16] Counter select one counts count-pin falls, zero counts core clocks.
// [RQ17] Trigger pin synchronised, falling edge found by comparing samples, once each.
// [RQ18] Baud mode rollover emits one-cycle ticks to selected serial clocks and reloads.
`timescale 1ns/100ps
module t2rc_top
  import t2rc_pkg::*;
(
  input  wire logic       clk_sys_i,          // Core clock, 25 MHz
  input  wire logic       rst_n_i,            // Asynchronous reset, active low
  input  wire logic [7:0] sfr_addr_i,         // Register address
  input  wire logic       sfr_wr_i,           // Write strobe
  input  wire logic [7:0] sfr_wdata_i,        // Write data
  input  wire logic       sfr_rd_i,           // Read strobe
  output logic      [7:0] sfr_rdata_o,        // Read data, one cycle after strobe
  input  wire logic       count_input_pin_i,  // External count pin
  input  wire logic       trigger_input_i,    // External trigger pin
  output logic            irq_o,              // Interrupt request level
  output logic            baud_rx_tick_o,     // Receive clock tick pulse
  output logic            baud_tx_tick_o      // Transmit clock tick pulse
);

  function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
    sfr_hit = (addr == target);
  endfunction : sfr_hit

  // Reset release through two flip-flops
  logic rst_meta_ff, rst_sync_n;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n  <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n  <= rst_meta_ff;
    end
  end

  // Pin samplers
  logic [T2RC_PIN_NUM-1:0] pin_vec;
  logic [T2RC_PIN_NUM-1:0] fall_vec;
  assign pin_vec[T2RC_PIN_COUNT] = count_input_pin_i;
  assign pin_vec[T2RC_PIN_TRIG]  = trigger_input_i;

  for (genvar gi = 0; gi < T2RC_PIN_NUM; gi++) begin : g_pin
    t2rc_fall_det u_fall (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_sync_n),
      .pin_i     (pin_vec[gi]),
      .fall_o    (fall_vec[gi])
    );
  end

  // State
  logic [7:0] live_count_low_byte_ff, live_count_high_byte_ff;  // RQ1
  logic [7:0] reload_hold_low_byte_ff, reload_hold_high_byte_ff;  // RQ1
  logic [7:0] timer_control_register_ff;
  logic [7:0] rdata_ff;
  logic       rx_tick_ff, tx_tick_ff;

  logic [7:0] nxt_cnt_lo, nxt_cnt_hi, nxt_hold_lo, nxt_hold_hi, nxt_ctrl, nxt_rdata;
  logic       nxt_rx_tick, nxt_tx_tick;

  // Control fields
  logic overflow_flag, external_event_flag, external_trigger_enable, counter_select;
  assign overflow_flag           = timer_control_register_ff[T2RC_BIT_OVF];
  assign external_event_flag     = timer_control_register_ff[T2RC_BIT_EXF];
  assign external_trigger_enable = timer_control_register_ff[T2RC_BIT_EXEN];
  assign counter_select          = timer_control_register_ff[T2RC_BIT_CNTS];

  t2rc_ctl_if ctl_bus ();
  assign ctl_bus.run_control           = timer_control_register_ff[T2RC_BIT_RUN];
  assign ctl_bus.capture_select        = timer_control_register_ff[T2RC_BIT_CAPS];
  assign ctl_bus.receive_clock_select  = timer_control_register_ff[T2RC_BIT_RCLK];
  assign ctl_bus.transmit_clock_select = timer_control_register_ff[T2RC_BIT_TRANSMIT_CLOCK_SELECT];

  t2rc_mode_dec u_mode (
    .ctl (ctl_bus)
  );

  t2rc_mode_t mode;
  assign mode = ctl_bus.mode;

  // Event terms
  logic [15:0] count16, hold16, count_step, nxt_count16;
  logic        step_en, roll, trig, ovf_set, exf_set, capture;
  logic        wr_cnt_lo, wr_cnt_hi, wr_hold_lo, wr_hold_hi, wr_ctrl;

  assign count16    = {live_count_high_byte_ff, live_count_low_byte_ff};
  assign hold16     = {reload_hold_high_byte_ff, reload_hold_low_byte_ff};
  assign count_step = count16 + T2RC_CNT_ONE;
  assign wr_cnt_lo  = sfr_wr_i && sfr_hit(sfr_addr_i, T2RC_ADDR_CNT_LO);   // RQ2
  assign wr_cnt_hi  = sfr_wr_i && sfr_hit(sfr_addr_i, T2RC_ADDR_CNT_HI);   // RQ2
  assign wr_hold_lo = sfr_wr_i && sfr_hit(sfr_addr_i, T2RC_ADDR_HOLD_LO);  // RQ3
  assign wr_hold_hi = sfr_wr_i && sfr_hit(sfr_addr_i, T2RC_ADDR_HOLD_HI);  // RQ3
  assign wr_ctrl    = sfr_wr_i && sfr_hit(sfr_addr_i, T2RC_ADDR_CTRL);     // RQ14

  // Count source: pin falls or every core clock
  assign step_en = (mode != T2RC_MODE_OFF) &&
                   (counter_select ? fall_vec[T2RC_PIN_COUNT] : 1'b1);  // RQ16
  assign roll    = step_en && (count16 == T2RC_CNT_MAX);
  // Trigger needs the timer running; in baud mode it only flags
  assign trig    = external_trigger_enable && fall_vec[T2RC_PIN_TRIG] && (mode != T2RC_MODE_OFF);  // RQ17

  always_comb begin
    nxt_count16 = count16;
    ovf_set     = 1'b0;
    exf_set     = 1'b0;
    capture     = 1'b0;
    nxt_rx_tick = 1'b0;
    nxt_tx_tick = 1'b0;
    case (mode)
      T2RC_MODE_RELOAD: begin
        if (roll || trig) begin
          nxt_count16 = hold16;  // RQ6 RQ7
        end else if (step_en) begin
          nxt_count16 = count_step;
        end
        ovf_set = roll;  // RQ6
        exf_set = trig;  // RQ7
      end
      T2RC_MODE_CAPTURE: begin
        if (step_en) begin
          nxt_count16 = count_step;  // RQ8
        end
        ovf_set = roll;  // RQ8
        capture = trig;  // RQ9
        exf_set = trig;  // RQ10
      end
      T2RC_MODE_BAUD: begin
        if (roll) begin
          nxt_count16 = hold16;  // RQ18
        end else if (step_en) begin
          nxt_count16 = count_step;
        end
        nxt_rx_tick = roll && ctl_bus.receive_clock_select;   // RQ18
        nxt_tx_tick = roll && ctl_bus.transmit_clock_select;  // RQ18
        exf_set     = trig;  // RQ13
      end
      default: begin
        nxt_count16 = count16;  // RQ4
      end
    endcase

    // Software writes win over counting, captures win over software
    nxt_cnt_lo  = wr_cnt_lo ? sfr_wdata_i : nxt_count16[7:0];
    nxt_cnt_hi  = wr_cnt_hi ? sfr_wdata_i : nxt_count16[15:8];
    nxt_hold_lo = capture ? count16[7:0]  : (wr_hold_lo ? sfr_wdata_i : reload_hold_low_byte_ff);   // RQ9
    nxt_hold_hi = capture ? count16[15:8] : (wr_hold_hi ? sfr_wdata_i : reload_hold_high_byte_ff);  // RQ9

    // Flag set beats a clear written in the same cycle
    nxt_ctrl = wr_ctrl ? sfr_wdata_i : timer_control_register_ff;
    nxt_ctrl[T2RC_BIT_OVF] = nxt_ctrl[T2RC_BIT_OVF] | ovf_set;  // RQ15 RQ12
    nxt_ctrl[T2RC_BIT_EXF] = nxt_ctrl[T2RC_BIT_EXF] | exf_set;  // RQ15

    nxt_rdata = rdata_ff;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        T2RC_ADDR_CTRL:    nxt_rdata = timer_control_register_ff;
        T2RC_ADDR_HOLD_LO: nxt_rdata = reload_hold_low_byte_ff;
        T2RC_ADDR_HOLD_HI: nxt_rdata = reload_hold_high_byte_ff;
        T2RC_ADDR_CNT_LO:  nxt_rdata = live_count_low_byte_ff;
        T2RC_ADDR_CNT_HI:  nxt_rdata = live_count_high_byte_ff;
        default:           nxt_rdata = T2RC_RDATA_NIL;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      live_count_low_byte_ff    <= T2RC_BYTE_RST;
      live_count_high_byte_ff   <= T2RC_BYTE_RST;
      reload_hold_low_byte_ff   <= T2RC_BYTE_RST;
      reload_hold_high_byte_ff  <= T2RC_BYTE_RST;
      timer_control_register_ff <= T2RC_CTRL_RST;  // RQ14
      rdata_ff                  <= T2RC_RDATA_NIL;
      rx_tick_ff                <= 1'b0;
      tx_tick_ff                <= 1'b0;
    end else begin
      live_count_low_byte_ff    <= nxt_cnt_lo;
      live_count_high_byte_ff   <= nxt_cnt_hi;
      reload_hold_low_byte_ff   <= nxt_hold_lo;
      reload_hold_high_byte_ff  <= nxt_hold_hi;
      timer_control_register_ff <= nxt_ctrl;
      rdata_ff                  <= nxt_rdata;
      rx_tick_ff                <= nxt_rx_tick;
      tx_tick_ff                <= nxt_tx_tick;
    end
  end

  assign sfr_rdata_o    = rdata_ff;
  assign irq_o          = overflow_flag | external_event_flag;  // RQ11 RQ13
  assign baud_rx_tick_o = rx_tick_ff;
  assign baud_tx_tick_o = tx_tick_ff;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_sync_n);

  logic wr_cnt_any;
  assign wr_cnt_any = wr_cnt_lo || wr_cnt_hi;

  AST_RELOAD_ON_ROLL: assert property (  // RQ6
    (mode == T2RC_MODE_RELOAD) && roll && !wr_cnt_any && !wr_ctrl
    |=> overflow_flag && (count16 == $past(hold16)))
    else $error("autoreload rollover did not reload or set overflow");

  AST_RELOAD_ON_TRIG: assert property (  // RQ7
    (mode == T2RC_MODE_RELOAD) && external_trigger_enable && fall_vec[T2RC_PIN_TRIG] && !wr_cnt_any && !wr_ctrl
    |=> external_event_flag && (count16 == $past(hold16)))
    else $error("trigger edge did not reload in autoreload mode");

  AST_CAPTURE_WRAP: assert property (  // RQ8
    (mode == T2RC_MODE_CAPTURE) && roll && !wr_cnt_any && !wr_ctrl
    |=> overflow_flag && (count16 == T2RC_CNT_ZERO))
    else $error("capture mode overflow did not wrap to zero with flag");

  AST_CAPTURE_COPY: assert property (  // RQ9
    (mode == T2RC_MODE_CAPTURE) && external_trigger_enable && fall_vec[T2RC_PIN_TRIG]
    |=> (hold16 == $past(count16)))
    else $error("trigger edge did not capture the count");

  AST_CAPTURE_FLAG: assert property (  // RQ10
    (mode == T2RC_MODE_CAPTURE) && trig && !wr_ctrl |=> external_event_flag)
    else $error("capture did not set the external-event flag");

  // Checked from the set terms, since irq_o is only an OR of the flag bits
  AST_IRQ_FOLLOWS: assert property (  // RQ11
    ovf_set || exf_set |=> irq_o)
    else $error("flag set event gave no interrupt request");

  AST_BAUD_NO_OVF: assert property (  // RQ12
    (mode == T2RC_MODE_BAUD) && !overflow_flag && !wr_ctrl |=> !overflow_flag)
    else $error("overflow flag set in baud mode");

  AST_BAUD_EXF: assert property (  // RQ13
    (mode == T2RC_MODE_BAUD) && trig && !wr_ctrl |=> external_event_flag ##0 irq_o)
    else $error("trigger in baud mode did not raise the event flag");

  AST_OVF_STICKY: assert property (  // RQ15
    overflow_flag && !wr_ctrl |=> overflow_flag)
    else $error("overflow flag cleared without a software write");

  AST_EXF_STICKY: assert property (  // RQ15
    external_event_flag && !wr_ctrl |=> external_event_flag)
    else $error("external-event flag cleared without a software write");

  AST_OFF_HOLD: assert property (  // RQ4
    (mode == T2RC_MODE_OFF) && !wr_cnt_any |=> $stable(count16))
    else $error("count moved while the timer was off");

  AST_TIMER_STEP: assert property (  // RQ16
    (mode != T2RC_MODE_OFF) && !counter_select && !roll && !trig && !wr_cnt_any
    |=> (count16 == $past(count_step)))
    else $error("timer did not advance by one per core clock");

  // A holding value of all ones rolls every cycle when counting core clocks, so back-to-back ticks are legal then
  AST_BAUD_TICK: assert property (  // RQ18
    baud_tx_tick_o |-> $past(ctl_bus.transmit_clock_select) && $past(mode == T2RC_MODE_BAUD)
    ##1 (!baud_tx_tick_o || $past(roll)))
    else $error("transmit tick without selection or longer than one cycle");

  AST_RX_TICK: assert property (  // RQ18
    baud_rx_tick_o |-> $past(ctl_bus.receive_clock_select) && $past(mode == T2RC_MODE_BAUD))
    else $error("receive tick without baud mode and selection");

  AST_OFF_NO_EVENT: assert property (  // RQ4
    (mode == T2RC_MODE_OFF) && !wr_hold_lo && !wr_hold_hi && !wr_ctrl
    |=> $stable(hold16) && $stable(timer_control_register_ff))
    else $error("capture or flag change while the timer was off");

  // Software writes land unless a capture claims the byte
  AST_CNT_LO_WRITE: assert property (  // RQ2
    wr_cnt_lo |=> (live_count_low_byte_ff == $past(sfr_wdata_i)))
    else $error("write to the count low byte did not land");

  AST_HOLD_HI_WRITE: assert property (  // RQ3
    wr_hold_hi && !capture |=> (reload_hold_high_byte_ff == $past(sfr_wdata_i)))
    else $error("write to the holding high byte did not land");

  AST_CTRL_READ: assert property (  // RQ14
    sfr_rd_i && sfr_hit(sfr_addr_i, T2RC_ADDR_CTRL)
    |=> (sfr_rdata_o == $past(timer_control_register_ff)))
    else $error("control register read returned a wrong value");

  COV_RELOAD_ROLL: cover property ((mode == T2RC_MODE_RELOAD) && roll);
  COV_CAPTURE_TRIG: cover property ((mode == T2RC_MODE_CAPTURE) && trig);
  COV_BAUD_TICK: cover property (baud_rx_tick_o && baud_tx_tick_o);
  COV_SET_VS_CLEAR: cover property (wr_ctrl && exf_set);

endmodule : t2rc_top

// *** tb/t2rc_pins_model.sv ***
// Far-side pin model: drives the count pin and the trigger pin of the timer.
// Assumes go requests are one-cycle pulses on the core clock; pins idle high.
`timescale 1ns/100ps
module t2rc_pins_model (
  input  wire logic clk_sys_i,          // Core clock
  input  wire logic cnt_go_i,           // Request one count pin pulse
  input  wire logic trig_go_i,          // Request one trigger pin fall
  output logic      count_input_pin_o,  // Count pin, idles high
  output logic      trigger_input_o     // Trigger pin, idles high
);
  logic [1:0] cnt_low_ff;
  logic [1:0] trig_low_ff;

  initial begin
    cnt_low_ff = 2'h0;
    trig_low_ff = 2'h0;
  end

  // Low for two clocks so the synchroniser cannot miss a pulse
  always @(posedge clk_sys_i) begin
    if (cnt_go_i) cnt_low_ff <= 2'h2;
    else if (cnt_low_ff != 2'h0) cnt_low_ff <= cnt_low_ff - 2'h1;
    if (trig_go_i) trig_low_ff <= 2'h2;
    else if (trig_low_ff != 2'h0) trig_low_ff <= trig_low_ff - 2'h1;
  end

  assign count_input_pin_o = (cnt_low_ff == 2'h0);
  assign trigger_input_o   = (trig_low_ff == 2'h0);
endmodule : t2rc_pins_model

// *** tb/test_timer2_reload_capture_baud.sv ***
// Self-checking bench for the reload/capture/baud timer.
// Assumes the pin model on the far side and register access on the core clock.
`timescale 1ns/100ps
module test_timer2_reload_capture_baud;
  import t2rc_pkg::*;
  logic       clk_sys_i;
  logic       rst_n_i;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic       sfr_rd;
  logic [7:0] sfr_rdata;
  logic       cnt_pin;
  logic       trig_pin;
  logic       irq;
  logic       rx_tick;
  logic       tx_tick;
  logic       cnt_go;
  logic       trig_go;
  int         n_errors;
  int         checks_done;

  t2rc_top t2rc_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr),
    .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata), .sfr_rd_i(sfr_rd), .sfr_rdata_o(sfr_rdata),
    .count_input_pin_i(cnt_pin), .trigger_input_i(trig_pin), .irq_o(irq),
    .baud_rx_tick_o(rx_tick), .baud_tx_tick_o(tx_tick));
  t2rc_pins_model t2rc_pins_model_inst (.clk_sys_i(clk_sys_i), .cnt_go_i(cnt_go),
    .trig_go_i(trig_go), .count_input_pin_o(cnt_pin), .trigger_input_o(trig_pin));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic summarize;
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check8

  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys_i);
    sfr_addr  <= addr;
    sfr_wdata <= data;
    sfr_wr    <= 1'b1;
    @(posedge clk_sys_i);
    sfr_wr    <= 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys_i);
    sfr_addr <= addr;
    sfr_rd   <= 1'b1;
    @(posedge clk_sys_i);
    sfr_rd   <= 1'b0;
    @(posedge clk_sys_i);
    data = sfr_rdata;
  endtask : sfr_read

  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
    logic [7:0] d;
    sfr_read(addr, d);
    check8(d, exp, what);
  endtask : read_check

  // Stop first so the 16-bit values load without the count moving
  task automatic setup(input logic [15:0] cnt, input logic [15:0] hold, input logic [7:0] ctrl);
    sfr_write(T2RC_ADDR_CTRL, 8'h00);
    sfr_write(T2RC_ADDR_CNT_HI, cnt[15:8]);
    sfr_write(T2RC_ADDR_CNT_LO, cnt[7:0]);
    sfr_write(T2RC_ADDR_HOLD_HI, hold[15:8]);
    sfr_write(T2RC_ADDR_HOLD_LO, hold[7:0]);
    sfr_write(T2RC_ADDR_CTRL, ctrl);
  endtask : setup

  task automatic pin_pulse(input bit trig);
    @(posedge clk_sys_i);
    if (trig) trig_go <= 1'b1;
    else cnt_go <= 1'b1;
    @(posedge clk_sys_i);
    trig_go <= 1'b0;
    cnt_go  <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
  endtask : pin_pulse

  task automatic test_reset_and_map;
    read_check(T2RC_ADDR_CTRL, 8'h00, "ctrl reset");
    read_check(T2RC_ADDR_CNT_HI, 8'h00, "cnt hi reset");
    sfr_write(8'hc9, 8'h5a);
    read_check(8'hc9, 8'h00, "unmapped read");
    sfr_write(T2RC_ADDR_HOLD_HI, 8'ha1);
    sfr_write(T2RC_ADDR_HOLD_LO, 8'hb2);
    sfr_write(T2RC_ADDR_CNT_HI, 8'hc3);
    sfr_write(T2RC_ADDR_CNT_LO, 8'hd4);
    read_check(T2RC_ADDR_HOLD_HI, 8'ha1, "hold hi");
    read_check(T2RC_ADDR_HOLD_LO, 8'hb2, "hold lo");
    read_check(T2RC_ADDR_CNT_HI, 8'hc3, "cnt hi");
    read_check(T2RC_ADDR_CNT_LO, 8'hd4, "cnt lo");
  endtask : test_reset_and_map

  task automatic test_reload_overflow;
    setup(16'hfffe, 16'h1234, 8'h04);
    repeat (10) @(posedge clk_sys_i);
    read_check(T2RC_ADDR_CTRL, 8'h84, "reload ovf flag");
    read_check(T2RC_ADDR_CNT_HI, 8'h12, "reload value");
    check8({7'h0, irq}, 8'h01, "irq on ovf");
    sfr_write(T2RC_ADDR_CTRL, 8'h00);
    @(posedge clk_sys_i);
    check8({7'h0, irq}, 8'h00, "irq after clear");
  endtask : test_reload_overflow

  task automatic test_reload_trigger;
    setup(16'h0100, 16'h5678, 8'h0c);
    pin_pulse(1'b1);
    read_check(T2RC_ADDR_CTRL, 8'h4c, "reload ext flag");
    read_check(T2RC_ADDR_CNT_HI, 8'h56, "trigger reload");
    read_check(T2RC_ADDR_CTRL, 8'h4c, "flag stays set");
  endtask : test_reload_trigger

  task automatic test_capture;
    setup(16'h3000, 16'h0000, 8'h0d);
    pin_pulse(1'b1);
    read_check(T2RC_ADDR_HOLD_HI, 8'h30, "captured hi");
    read_check(T2RC_ADDR_CTRL, 8'h4d, "capture ext flag");
    check8({7'h0, irq}, 8'h01, "irq on ext");
    setup(16'hfff8, 16'h1111, 8'h05);
    repeat (20) @(posedge clk_sys_i);
    read_check(T2RC_ADDR_CTRL, 8'h85, "capture ovf");
    read_check(T2RC_ADDR_CNT_HI, 8'h00, "wrap no reload");
  endtask : test_capture

  task automatic baud_run(input logic [7:0] ctrl, input int exp_rx, input int exp_tx);
    int nrx;
    int ntx;
    nrx = 0;
    ntx = 0;
    setup(16'hfffa, 16'hfffa, ctrl);
    repeat (4) @(posedge clk_sys_i);
    // Ticks are sampled mid-cycle, away from the edge that launches them
    repeat (60) begin
      @(negedge clk_sys_i);
      if (rx_tick === 1'b1) nrx++;
      if (tx_tick === 1'b1) ntx++;
    end
    check8(8'(nrx), 8'(exp_rx), "rx ticks");
    check8(8'(ntx), 8'(exp_tx), "tx ticks");
    read_check(T2RC_ADDR_CNT_HI, 8'hff, "baud reload");
  endtask : baud_run

  task automatic test_baud;
    baud_run(8'h35, 10, 10);
    read_check(T2RC_ADDR_CTRL, 8'h35, "no ovf in baud");
    baud_run(8'h24, 10, 0);
    baud_run(8'h1c, 0, 10);
    pin_pulse(1'b1);
    read_check(T2RC_ADDR_CTRL, 8'h5c, "baud ext flag");
    check8({7'h0, irq}, 8'h01, "baud irq");
  endtask : test_baud

  task automatic test_counter_and_off;
    setup(16'h0000, 16'h0000, 8'h06);
    repeat (3) pin_pulse(1'b0);
    sfr_write(T2RC_ADDR_CTRL, 8'h00);
    read_check(T2RC_ADDR_CNT_LO, 8'h03, "pin count");
    setup(16'h0042, 16'h0000, 8'h09);
    pin_pulse(1'b1);
    read_check(T2RC_ADDR_CTRL, 8'h09, "off ignores trigger");
    read_check(T2RC_ADDR_CNT_LO, 8'h42, "off frozen");
    read_check(T2RC_ADDR_HOLD_LO, 8'h00, "off no capture");
  endtask : test_counter_and_off

  initial begin
    n_errors = 0;
    checks_done = 0;
    rst_n_i = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd = 1'b0;
    cnt_go = 1'b0;
    trig_go = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    test_reset_and_map();
    test_reload_overflow();
    test_reload_trigger();
    test_capture();
    test_baud();
    test_counter_and_off();
    summarize();
  end

  // Whole run is well under 1500 cycles
  initial begin
    #(40 * 5000);
    n_errors++;
    summarize();
  end
endmodule : test_timer2_reload_capture_baud
